// ---- hw/pif_defs.vh ----
/*
 * Constants of the peripheral interrupt flag block: register byte
 * addresses, flag bit positions, reset values, compare unit modes and
 * bus response codes.
 * Assumes inclusion by bare name from the event generator and top-level design files of the block.
 */
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH

// Byte addresses
`define PIF_ADDR_FLAGS      8'h0c
`define PIF_ADDR_MASK       8'h10
`define PIF_ADDR_STATUS     8'h14
`define PIF_ADDR_CTRL       8'h18

// Flag bit positions
`define PIF_BIT_PARALLEL    7
`define PIF_BIT_RESERVED    6
`define PIF_BIT_SERIAL_RX   5
`define PIF_BIT_SERIAL_TX   4
`define PIF_BIT_SYNC        3
`define PIF_BIT_CAPCMP      2
`define PIF_BIT_PERIOD      1
`define PIF_BIT_OVERFLOW    0

// Bits written by software in the flag register
`define PIF_FLAGS_WR_MASK   8'hcf

// Reset values
`define PIF_RST_FLAGS       8'h00
`define PIF_RST_MASK        8'h00
`define PIF_RST_STATUS      8'h00
`define PIF_RST_CTRL        2'h0

// Capture/compare unit modes
`define PIF_MODE_CAPTURE    2'h0
`define PIF_MODE_COMPARE    2'h1
`define PIF_MODE_PWM        2'h2

// Bus responses
`define PIF_RESP_OKAY       2'h0
`define PIF_RESP_SLVERR     2'h2

`endif

// ---- hw/pif_sticky_bank.v ----
/*
 * Bank of sticky bits: a set pulse wins over a clear or a load in the
 * same cycle.
 * Assumes set, load and value come from logic on clk.
 */
`timescale 1ns/1ps
module pif_sticky_bank
#(
   parameter WIDTH = 8
)
(
   // Clock and reset
   input  wire             clk,
   input  wire             resetn,
   // Control
   input  wire [WIDTH-1:0] set,
   input  wire [WIDTH-1:0] load,
   input  wire [WIDTH-1:0] value,
   // State
   output reg  [WIDTH-1:0] bits
);

   wire [WIDTH-1:0] next_bits;

   // Set beats load; load takes software value
   assign next_bits = set | (load & value) | (~load & bits);

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         bits <= {WIDTH{1'b0}};
      else
         bits <= next_bits;
   end

endmodule // pif_sticky_bank

// ---- hw/pif_event_gen.v ----
/*
 * Forms one-cycle event pulses for the flag bits from the peripheral
 * strobes and buffer levels.
 * Assumes all inputs come from on-chip logic on clk.
 */
`timescale 1ns/1ps
`include "pif_defs.vh"
module pif_event_gen
(
   // Clock and reset
   input  wire       clk,
   input  wire       resetn,
   // Mode of the capture/compare unit
   input  wire [1:0] capcmp_mode,
   // Peripheral strobes and levels
   input  wire       parallel_access_done,
   input  wire       serial_rx_full,
   input  wire       serial_tx_full,
   input  wire       sync_transfer_done,
   input  wire       capture_strobe,
   input  wire       compare_match,
   input  wire       period_match,
   input  wire       wide_timer_rollover,
   // Events
   output wire [7:0] flag_set,
   output wire [7:0] irq_event
);

   reg        rx_prev;
   reg        tx_prev;
   wire       capcmp_set;

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_prev <= 1'b0;
         tx_prev <= 1'b0;
      end
      else
      begin
         rx_prev <= serial_rx_full;
         tx_prev <= serial_tx_full;
      end
   end

   // Capture or compare source by mode, none in PWM
   assign capcmp_set = ((capcmp_mode == `PIF_MODE_CAPTURE) && capture_strobe)
                     | ((capcmp_mode == `PIF_MODE_COMPARE) && compare_match);

   assign flag_set[`PIF_BIT_PARALLEL]  = parallel_access_done;
   assign flag_set[`PIF_BIT_RESERVED]  = 1'b0;
   assign flag_set[`PIF_BIT_SERIAL_RX] = 1'b0;
   assign flag_set[`PIF_BIT_SERIAL_TX] = 1'b0;
   assign flag_set[`PIF_BIT_SYNC]      = sync_transfer_done;
   assign flag_set[`PIF_BIT_CAPCMP]    = capcmp_set;
   assign flag_set[`PIF_BIT_PERIOD]    = period_match;
   assign flag_set[`PIF_BIT_OVERFLOW]  = wide_timer_rollover;

   // Interrupt events: set pulses plus buffer level rising edges
   assign irq_event = flag_set
                    | ({7'h00, serial_rx_full & ~rx_prev} << `PIF_BIT_SERIAL_RX)
                    | ({7'h00, serial_tx_full & ~tx_prev} << `PIF_BIT_SERIAL_TX);

endmodule // pif_event_gen

// ---- hw/pif_top.v ----
/*
 * Peripheral interrupt flag register with an AXI4-Lite slave, a sticky
 * interrupt status, a mask and one level interrupt output.
 * Assumes peripheral strobes are one-cycle pulses on clk and buffer
 * levels are driven from logic on clk.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pif_defs.vh"
module pif_top
(
   // Clock and reset
   input  wire       clk,
   input  wire       resetn,
   // Write address channel
   input  wire [7:0] s_axi_awaddr,
   input  wire [2:0] s_axi_awprot,
   input  wire       s_axi_awvalid,
   output wire       s_axi_awready,
   // Write data channel
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0] s_axi_wstrb,
   input  wire       s_axi_wvalid,
   output wire       s_axi_wready,
   // Write response channel
   output reg  [1:0] s_axi_bresp,
   output reg        s_axi_bvalid,
   input  wire       s_axi_bready,
   // Read address channel
   input  wire [7:0] s_axi_araddr,
   input  wire [2:0] s_axi_arprot,
   input  wire       s_axi_arvalid,
   output wire       s_axi_arready,
   // Read data channel
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0] s_axi_rresp,
   output reg        s_axi_rvalid,
   input  wire       s_axi_rready,
   // Peripheral events and levels
   input  wire       parallel_access_done,
   input  wire       serial_rx_full,
   input  wire       serial_tx_full,
   input  wire       sync_transfer_done,
   input  wire       capture_strobe,
   input  wire       compare_match,
   input  wire       period_match,
   input  wire       wide_timer_rollover,
   // Interrupt
   output wire       irq
);

   function is_mapped;
      input [7:0] addr;
      begin
         is_mapped = (addr == `PIF_ADDR_FLAGS) || (addr == `PIF_ADDR_MASK)
                  || (addr == `PIF_ADDR_STATUS) || (addr == `PIF_ADDR_CTRL);
      end
   endfunction

   // Held write request
   reg        aw_held;
   reg [7:0]  aw_addr;
   reg        w_held;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   wire       wr_fire;
   wire       wr_low;

   // Software registers
   reg [7:0]  irq_mask;
   reg [1:0]  capcmp_mode;
   wire [7:0] sticky_flags;
   wire [7:0] irq_status;
   wire [7:0] flags_view;

   // Events and loads
   wire [7:0] flag_set;
   wire [7:0] irq_event;
   wire [7:0] flags_load;
   wire [7:0] status_load;

   reg [31:0] next_rdata;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_low  = wr_fire && w_strb[0];

   // Write address and data taken in either order
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held  <= 1'b0;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_held <= 1'b0;
      end
   end

   // Write response
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `PIF_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= is_mapped(aw_addr) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Mask and mode registers
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_mask    <= `PIF_RST_MASK;
         capcmp_mode <= `PIF_RST_CTRL;
      end
      else
      begin
         if (wr_low && (aw_addr == `PIF_ADDR_MASK))
            irq_mask <= w_data[7:0];
         if (wr_low && (aw_addr == `PIF_ADDR_CTRL))
            capcmp_mode <= w_data[1:0];
      end
   end

   pif_event_gen u_events
   (
      .clk                  (clk),
      .resetn               (resetn),
      .capcmp_mode          (capcmp_mode),
      .parallel_access_done (parallel_access_done),
      .serial_rx_full       (serial_rx_full),
      .serial_tx_full       (serial_tx_full),
      .sync_transfer_done   (sync_transfer_done),
      .capture_strobe       (capture_strobe),
      .compare_match        (compare_match),
      .period_match         (period_match),
      .wide_timer_rollover  (wide_timer_rollover),
      .flag_set             (flag_set),
      .irq_event            (irq_event)
   );

   // Software write loads writable flags; events win, enables ignored
   assign flags_load = (wr_low && (aw_addr == `PIF_ADDR_FLAGS)) ?
                       `PIF_FLAGS_WR_MASK : 8'h00;

   pif_sticky_bank #(.WIDTH(8)) u_flags
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (flag_set),
      .load   (flags_load),
      .value  (w_data[7:0]),
      .bits   (sticky_flags)
   );

   // Write one to clear status bits
   assign status_load = (wr_low && (aw_addr == `PIF_ADDR_STATUS)) ?
                        w_data[7:0] : 8'h00;

   pif_sticky_bank #(.WIDTH(8)) u_status
   (
      .clk    (clk),
      .resetn (resetn),
      .set    (irq_event),
      .load   (status_load),
      .value  (8'h00),
      .bits   (irq_status)
   );

   // Serial buffer bits follow the buffer levels
   assign flags_view = {sticky_flags[7:6],
                        serial_rx_full,
                        serial_tx_full,
                        sticky_flags[3:0]};

   assign irq = |(irq_status & irq_mask);

   always @*
   begin
      next_rdata = 32'h00000000;
      case (s_axi_araddr)
         `PIF_ADDR_FLAGS:  next_rdata[7:0] = flags_view;
         `PIF_ADDR_MASK:   next_rdata[7:0] = irq_mask;
         `PIF_ADDR_STATUS: next_rdata[7:0] = irq_status;
         `PIF_ADDR_CTRL:   next_rdata[1:0] = capcmp_mode;
         default:          next_rdata = 32'h00000000;
      endcase
   end

   // Read channel
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PIF_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= is_mapped(s_axi_araddr) ? `PIF_RESP_OKAY : `PIF_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule // pif_top

// ---- sim/pif_top_monitor.sv ----
/* Checker on the flag block ports: bus handshakes and answer timing.
   Assumes it is bound to pif_top and sees its ports only. */
`timescale 1ns/1ps
module pif_top_monitor
(
   // Clock and reset
   input logic        clk,
   input logic        resetn,
   // Register bus
   input logic [7:0]  s_axi_araddr,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic [1:0]  s_axi_bresp,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0]  s_axi_rresp,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire mapped = s_axi_araddr inside {8'h0c, 8'h10, 8'h14, 8'h18};

   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   chk_read_lat: assert property (ar_hs |=> s_axi_rvalid) else $error("read late");
   chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
   chk_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("aw open");
   chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write late");
   chk_read_unmapped: assert property (
      ar_hs && !mapped |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read");
   chk_read_mapped: assert property (
      ar_hs && mapped |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
      else $error("mapped read");
endmodule // pif_top_monitor

bind pif_top pif_top_monitor u_mon (.clk, .resetn, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// ---- sim/pif_periph_model.sv ----
/* Peripheral side: turns requests into one-cycle strobes, holds levels.
   Assumes requests from the bench on clk. */
`timescale 1ns/1ps
module pif_periph_model
(
   // Clock and reset
   input  logic       clk,
   input  logic       resetn,
   // Requests
   input  logic [7:0] req,
   input  logic [1:0] lvl,
   // Strobes and levels
   output logic [7:0] ev
);
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ev <= 8'h00;
      else
         ev <= {req[7:6], lvl, req[3:0]};
   end
endmodule // pif_periph_model

// ---- sim/test_pif_top.sv ----
/* Self-checking bench: bus master tasks, event scenarios, queued checks.
   Assumes the peripheral model and the bound checker. */
`timescale 1ns/1ps
module test_pif_top;
   logic        clk = 0, resetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
   logic [7:0]  awa = 0, ara = 0, req = 0, e;
   logic [31:0] wd = 0;
   logic [1:0]  lvl = 0;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  ev;
   wire         awr, wr_ok, bv, arr, rv, irq;
   logic [33:0] wq[$], rq[$];
   int          fail_count = 0, n_compared = 0, i;

   pif_periph_model u_model (.clk, .resetn, .req, .lvl, .ev);
   pif_top DUT (.clk, .resetn, .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_ok),
      .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
      .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rrdy), .parallel_access_done(ev[7]),
      .compare_match(ev[6]), .serial_rx_full(ev[5]), .serial_tx_full(ev[4]),
      .sync_transfer_done(ev[3]), .capture_strobe(ev[2]), .period_match(ev[1]),
      .wide_timer_rollover(ev[0]), .irq);

   always #12.5 clk = ~clk;

   task cmp(input string n, input logic [33:0] x, input logic [33:0] g);
      n_compared++;
      if (g !== x)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask

   task cmp_resp(input logic [33:0] x, input logic [1:0] g);
      cmp("bresp", x, {32'h0, g});
   endtask

   task cmp_read(input logic [33:0] x, input logic [33:0] g);
      cmp("read", x, g);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      logic da, dw;
      wq.push_back({32'h0, r});
      da = 0;
      dw = 0;
      @(posedge clk);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      while (!(da && dw))
      begin
         @(negedge clk);
         da = da || awr;
         dw = dw || wr_ok;
         @(posedge clk);
         if (da) awv <= 0;
         if (dw) wv <= 0;
      end
      // Late ready lets the response stand a while
      repeat ($urandom % 3) @(posedge clk);
      brdy <= 1;
      do @(negedge clk); while (!bv);
      @(posedge clk);
      brdy <= 0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] x, input logic [1:0] r);
      rq.push_back({r, 24'h0, x});
      @(posedge clk);
      ara <= a;
      arv <= 1;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 0;
      repeat ($urandom % 3) @(posedge clk);
      rrdy <= 1;
      do @(negedge clk); while (!rv);
      @(posedge clk);
      rrdy <= 0;
   endtask

   task fire(input logic [7:0] r);
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= 8'h00;
      repeat (3) @(posedge clk);
   endtask

   task irq_is(input logic x);
      @(negedge clk);
      cmp("irq", {33'h0, x}, {33'h0, irq});
   endtask

   task give_verdict;
      $display("compared %0d wrong %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Response checker: oldest note against each answer
   always @(negedge clk)
   begin
      if (resetn && bv && brdy) cmp_resp(wq.pop_front(), bresp);
      if (resetn && rv && rrdy) cmp_read(rq.pop_front(), {rresp, rdata});
   end

   initial
   begin
      #(25ns * 20000);
      fail_count++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(32'hb8f7));
      repeat (2) @(posedge clk);
      resetn <= 1;
      for (i = 12; i <= 24; i += 4) rd(i[7:0], 8'h00, 2'h0);
      rd(8'h1c, 8'h00, 2'h2);
      wr(8'h1c, 8'hff, 2'h2);
      rd(8'h10, 8'h00, 2'h0);
      // Sticky flags, mask clear, also counted in status
      for (i = 0; i < 8; i++)
      begin
         e = 8'h01 << i;
         if (e & 8'h8f)
         begin
            fire(e);
            irq_is(0);
            rd(8'h0c, e, 2'h0);
            rd(8'h0c, e, 2'h0);
            rd(8'h14, e, 2'h0);
            wr(8'h14, e, 2'h0);
            wr(8'h0c, 8'h00, 2'h0);
            rd(8'h0c, 8'h00, 2'h0);
         end
      end
      // Capture counts only in capture mode, compare only in compare mode
      for (i = 0; i < 4; i++)
      begin
         wr(8'h18, i[7:0], 2'h0);
         rd(8'h18, i[7:0], 2'h0);
         fire(8'h04);
         rd(8'h0c, (i == 0) ? 8'h04 : 8'h00, 2'h0);
         wr(8'h0c, 8'h00, 2'h0);
         fire(8'h40);
         rd(8'h0c, (i == 1) ? 8'h04 : 8'h00, 2'h0);
         wr(8'h0c, 8'h00, 2'h0);
      end
      // Buffer levels mirrored, writes to them ignored
      for (i = 0; i < 4; i++)
      begin
         lvl <= 2'($urandom);
         repeat (3) @(posedge clk);
         rd(8'h0c, {2'h0, lvl, 4'h0}, 2'h0);
         wr(8'h0c, {2'h0, ~lvl, 4'h0}, 2'h0);
         rd(8'h0c, {2'h0, lvl, 4'h0}, 2'h0);
      end
      lvl <= 2'h0;
      wr(8'h14, 8'hff, 2'h0);
      // Interrupt raised, masked and cleared
      wr(8'h10, 8'h02, 2'h0);
      fire(8'h02);
      irq_is(1);
      fire(8'h01);
      wr(8'h14, 8'h02, 2'h0);
      irq_is(0);
      rd(8'h0c, 8'h03, 2'h0);
      wr(8'h10, 8'h01, 2'h0);
      irq_is(1);
      wr(8'h14, 8'h01, 2'h0);
      irq_is(0);
      give_verdict();
   end
endmodule // test_pif_top
